// ===== logic/bcce_pkg.sv
// Package of constants and types for the bit, call and clear execution unit
// How it works
// RULE1 - Bit set forces chosen bit of data register to one, flags untouched.
// RULE2 - Skip-if-one drops the next instruction as a no-op when bit is one.
// RULE3 - Absolute call pushes PC plus one, loads 11-bit target, upper bits from page latch.
// RULE4 - Absolute call takes two cycles and leaves all flags unchanged.
// RULE5 - Watchdog restart clears counter and prescaler, sets time-out and power-down flags.
// RULE6 - Indirect call pushes PC plus one, loads W low, page latch high, two cycles.
// RULE7 - Complement inverts register, writes W or register by destination, updates zero.
// RULE8 - Clear writes zero to register and always sets the zero flag.
// RULE9 - Decrement subtracts one, writes W or register by destination, updates zero only.
// RULE10 - Plain operations take one cycle and advance the program counter by one.
package bcce_pkg;

    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ADDR_W     = 7;
    localparam int unsigned PC_W       = 15;
    localparam int unsigned PAGE_W     = 7;
    localparam int unsigned LIT_W      = 11;
    localparam int unsigned BIT_SEL_W  = 3;
    localparam int unsigned REG_COUNT  = 128;
    localparam int unsigned STACK_DEF  = 16;
    localparam int unsigned PAGE_LO    = 3;
    localparam int unsigned PC_HI_LO   = 11;

    localparam logic [PC_W-1:0]   PC_RESET   = 15'h0000;
    localparam logic [DATA_W-1:0] W_RESET    = 8'h00;
    localparam logic [DATA_W-1:0] REG_RESET  = 8'h00;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 7'h00;
    localparam logic              Z_RESET    = 1'b0;
    localparam logic              TO_RESET   = 1'b1;
    localparam logic              PD_RESET   = 1'b1;

    typedef enum logic [3:0] {
        BCCE_NOP   = 4'h0,
        BCCE_BSET  = 4'h1,
        BCCE_SKIP1 = 4'h2,
        BCCE_CALL  = 4'h3,
        BCCE_WDTR  = 4'h4,
        BCCE_INDIRECT_SUBROUTINE_CALL = 4'h5,
        BCCE_COMP  = 4'h6,
        BCCE_CLR   = 4'h7,
        BCCE_DEC   = 4'h8
    } bcce_op_e;

    typedef struct packed {
        logic                 valid;
        bcce_op_e             op;
        logic [ADDR_W-1:0]    f_addr;
        logic [BIT_SEL_W-1:0] bit_sel;
        logic                 dest;
        logic [LIT_W-1:0]     lit;
    } bcce_instr_s;

    typedef struct packed {
        logic               zero_flag;
        logic               time_out_flag;
        logic               power_down_flag;
    } bcce_status_s;

endpackage : bcce_pkg

// ===== logic/bcce_exec.sv
// Execution unit for bit set, skip, calls, watchdog restart, complement, clear and decrement
`timescale 1ns/1ps
`default_nettype none

module bcce_exec #(
    parameter int unsigned STACK_DEPTH = bcce_pkg::STACK_DEF
) (
    input  wire logic                            mclk,
    input  wire logic                            rst_n,
    input  wire bcce_pkg::bcce_instr_s           instr,
    input  wire logic                            page_we,
    input  wire logic [bcce_pkg::PAGE_W-1:0]     page_wdata,
    input  wire logic [bcce_pkg::ADDR_W-1:0]     peek_addr,
    output logic                                 ready_r,
    output logic [bcce_pkg::PC_W-1:0]            pc_r,
    output logic [bcce_pkg::DATA_W-1:0]          w_r,
    output logic [bcce_pkg::PAGE_W-1:0]          page_high_latch_r,
    output bcce_pkg::bcce_status_s               status_r,
    output logic [bcce_pkg::PC_W-1:0]            stack_top_r,
    output logic [$clog2(STACK_DEPTH)-1:0]       stack_ptr_r,
    output logic                                 watchdog_restart_r,
    output logic                                 skip_pending_r,
    output logic [bcce_pkg::DATA_W-1:0]          peek_data_r
);

    localparam int unsigned SP_W = $clog2(STACK_DEPTH);

    // Depth must give a pointer that wraps cleanly
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("STACK_DEPTH must be a power of two, at least 2");
    end

    logic [bcce_pkg::DATA_W-1:0]   regs_r   [bcce_pkg::REG_COUNT];
    logic [bcce_pkg::DATA_W-1:0]   regs_nxt [bcce_pkg::REG_COUNT];
    logic                          ready_nxt;
    logic [bcce_pkg::PC_W-1:0]     pc_nxt;
    logic [bcce_pkg::DATA_W-1:0]   w_nxt;
    logic [bcce_pkg::PAGE_W-1:0]   page_nxt;
    bcce_pkg::bcce_status_s        status_nxt;
    logic [bcce_pkg::PC_W-1:0]     stack_top_nxt;
    logic [SP_W-1:0]               stack_ptr_nxt;
    logic                          watchdog_restart_nxt;
    logic                          skip_nxt;
    logic [bcce_pkg::DATA_W-1:0]   peek_nxt;
    logic [bcce_pkg::DATA_W-1:0]   operand;
    logic [bcce_pkg::DATA_W-1:0]   result;
    logic [bcce_pkg::PC_W-1:0]     pc_inc;
    logic                          accept;
    logic                          execute;

    // Zero test shared by complement and decrement
    function automatic logic is_zero(input logic [bcce_pkg::DATA_W-1:0] v);
        return v == 8'h00;
    endfunction : is_zero

    // Operations that push a return address and need a dead second cycle
    function automatic logic is_call(input bcce_pkg::bcce_op_e op);
        return op == bcce_pkg::BCCE_CALL || op == bcce_pkg::BCCE_INDIRECT_SUBROUTINE_CALL;
    endfunction : is_call

    // Accepted this edge; a pending skip turns it into a no-op
    assign accept  = instr.valid && ready_r;
    assign execute = accept && !skip_pending_r;
    assign operand = regs_r[instr.f_addr];
    assign pc_inc  = pc_r + 15'h0001;

    // Sequencing group: program counter, dead call cycle and skip flag
    always_comb begin
        ready_nxt = 1'b1;
        pc_nxt    = pc_r;
        skip_nxt  = skip_pending_r;
        if (accept) begin
            pc_nxt = pc_inc; // see RULE10
            if (skip_pending_r) begin
                skip_nxt = 1'b0; // see RULE2
            end
        end
        if (execute) begin
            case (instr.op)
                bcce_pkg::BCCE_SKIP1: begin
                    skip_nxt = operand[instr.bit_sel]; // see RULE2
                end
                bcce_pkg::BCCE_CALL: begin
                    pc_nxt = {page_high_latch_r[bcce_pkg::PAGE_W-1:bcce_pkg::PAGE_LO], instr.lit}; // see RULE3
                end
                bcce_pkg::BCCE_INDIRECT_SUBROUTINE_CALL: begin
                    pc_nxt = {page_high_latch_r, w_r}; // see RULE6
                end
                default: begin
                end
            endcase
            if (is_call(instr.op)) begin
                ready_nxt = 1'b0; // see RULE4
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ready_r        <= 1'b1;
            pc_r           <= bcce_pkg::PC_RESET;
            skip_pending_r <= 1'b0;
        end else begin
            ready_r        <= ready_nxt;
            pc_r           <= pc_nxt;
            skip_pending_r <= skip_nxt;
        end
    end

    // Data group: register file, working register, flags and restart pulse
    always_comb begin
        regs_nxt             = regs_r;
        w_nxt                = w_r;
        status_nxt           = status_r;
        watchdog_restart_nxt = 1'b0;
        result               = operand;
        if (execute) begin
            case (instr.op)
                bcce_pkg::BCCE_BSET: begin
                    result[instr.bit_sel]  = 1'b1;
                    regs_nxt[instr.f_addr] = result; // see RULE1
                end
                bcce_pkg::BCCE_WDTR: begin
                    watchdog_restart_nxt       = 1'b1; // see RULE5
                    status_nxt.time_out_flag   = 1'b1; // see RULE5
                    status_nxt.power_down_flag = 1'b1; // see RULE5
                end
                bcce_pkg::BCCE_COMP: begin
                    result               = ~operand; // see RULE7
                    status_nxt.zero_flag = is_zero(result);
                    if (instr.dest) begin
                        regs_nxt[instr.f_addr] = result;
                    end else begin
                        w_nxt = result;
                    end
                end
                bcce_pkg::BCCE_CLR: begin
                    regs_nxt[instr.f_addr] = bcce_pkg::REG_RESET; // see RULE8
                    status_nxt.zero_flag   = 1'b1; // see RULE8
                end
                bcce_pkg::BCCE_DEC: begin
                    result               = operand - 8'h01; // see RULE9
                    status_nxt.zero_flag = is_zero(result);
                    if (instr.dest) begin
                        regs_nxt[instr.f_addr] = result;
                    end else begin
                        w_nxt = result;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < bcce_pkg::REG_COUNT; i++) begin
                regs_r[i] <= bcce_pkg::REG_RESET;
            end
            w_r                      <= bcce_pkg::W_RESET;
            status_r.zero_flag       <= bcce_pkg::Z_RESET;
            status_r.time_out_flag   <= bcce_pkg::TO_RESET;
            status_r.power_down_flag <= bcce_pkg::PD_RESET;
            watchdog_restart_r       <= 1'b0;
        end else begin
            regs_r             <= regs_nxt;
            w_r                <= w_nxt;
            status_r           <= status_nxt;
            watchdog_restart_r <= watchdog_restart_nxt;
        end
    end

    // Return stack group; only the top entry and a wrapping count are kept
    always_comb begin
        stack_top_nxt = stack_top_r;
        stack_ptr_nxt = stack_ptr_r;
        if (execute && is_call(instr.op)) begin
            stack_top_nxt = pc_inc; // see RULE3
            stack_ptr_nxt = stack_ptr_r + {{(SP_W-1){1'b0}}, 1'b1}; // see RULE6
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stack_top_r <= bcce_pkg::PC_RESET;
            stack_ptr_r <= '0;
        end else begin
            stack_top_r <= stack_top_nxt;
            stack_ptr_r <= stack_ptr_nxt;
        end
    end

    // Page latch group, loaded from outside whether or not an instruction runs
    always_comb begin
        page_nxt = page_high_latch_r;
        if (page_we) begin
            page_nxt = page_wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            page_high_latch_r <= bcce_pkg::PAGE_RESET;
        end else begin
            page_high_latch_r <= page_nxt;
        end
    end

    // Observation port, one edge behind its address
    always_comb begin
        peek_nxt = regs_r[peek_addr];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            peek_data_r <= bcce_pkg::REG_RESET;
        end else begin
            peek_data_r <= peek_nxt;
        end
    end

endmodule : bcce_exec

`default_nettype wire

// ===== verification/bcce_chk.sv
// Assertion checker for the execution unit
`timescale 1ns/1ps
`default_nettype none
module bcce_chk (
    input wire logic                        mclk,
    input wire logic                        rst_n,
    input wire bcce_pkg::bcce_instr_s       instr,
    input wire logic                        ready_r,
    input wire logic [bcce_pkg::PC_W-1:0]   pc_r,
    input wire logic [bcce_pkg::DATA_W-1:0] w_r,
    input wire logic [bcce_pkg::PAGE_W-1:0] page_high_latch_r,
    input wire bcce_pkg::bcce_status_s      status_r,
    input wire logic [bcce_pkg::PC_W-1:0]   stack_top_r,
    input wire logic                        watchdog_restart_r,
    input wire logic                        skip_pending_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic acc;
    assign acc = instr.valid && ready_r && !skip_pending_r;
    AST_BSET: assert property (acc && instr.op == bcce_pkg::BCCE_BSET |=> $stable(status_r))
        else $error("bit set changed flags");
    AST_SKIP: assert property (instr.valid && ready_r && skip_pending_r
        |=> !skip_pending_r && pc_r == $past(pc_r) + 15'h1 && $stable(w_r)) else $error("skip not dropped");
    AST_CALL: assert property (acc && instr.op == bcce_pkg::BCCE_CALL
        |=> pc_r == {$past(page_high_latch_r[6:3]), $past(instr.lit)} && stack_top_r == $past(pc_r) + 15'h1)
        else $error("call target wrong");
    AST_CALL_TWO: assert property (acc && instr.op == bcce_pkg::BCCE_CALL
        |=> !ready_r && $stable(status_r) ##1 ready_r) else $error("call timing wrong");
    AST_WDT: assert property (acc && instr.op == bcce_pkg::BCCE_WDTR
        |=> watchdog_restart_r && status_r.time_out_flag && status_r.power_down_flag) else $error("restart wrong");
    AST_INDIRECT_SUBROUTINE_CALL: assert property (acc && instr.op == bcce_pkg::BCCE_INDIRECT_SUBROUTINE_CALL
        |=> pc_r == {$past(page_high_latch_r), $past(w_r)} && !ready_r) else $error("indirect call wrong");
    AST_COMP: assert property (acc && instr.op == bcce_pkg::BCCE_COMP && instr.dest |=> $stable(w_r))
        else $error("complement hit w");
    AST_COMP_Z: assert property (acc && instr.op == bcce_pkg::BCCE_COMP && !instr.dest
        |=> status_r.zero_flag == (w_r == 8'h00)) else $error("complement zero flag wrong");
    AST_CLR: assert property (acc && instr.op == bcce_pkg::BCCE_CLR |=> status_r.zero_flag)
        else $error("clear left zero low");
    AST_DEC: assert property (acc && instr.op == bcce_pkg::BCCE_DEC |=> $stable(status_r[1:0]))
        else $error("decrement hit other flags");
    AST_PLAIN: assert property (acc && instr.op inside {bcce_pkg::BCCE_BSET, bcce_pkg::BCCE_CLR,
        bcce_pkg::BCCE_DEC} |=> ready_r && pc_r == $past(pc_r) + 15'h1) else $error("plain op pc wrong");
endmodule : bcce_chk
`default_nettype wire

// ===== verification/bcce_exec_tb.sv
// Testbench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module bcce_exec_tb;
    logic                  mclk = 0, rst_n = 0, page_we = 0, ready_r, watchdog_restart_r, skip_pending_r;
    bcce_pkg::bcce_instr_s instr = '0;
    bcce_pkg::bcce_status_s status_r;
    logic [6:0]            page_wdata = '0, peek_addr = '0, page_high_latch_r, ep = '0;
    logic [14:0]           pc_r, stack_top_r, epc = '0, old;
    logic [7:0]            w_r, peek_data_r, ew = '0;
    logic [3:0]            stack_ptr_r;
    int                    n_mismatch = 0, checks_done = 0, cyc = 0;
    bcce_exec bcce_exec_i (.mclk, .rst_n, .instr, .page_we, .page_wdata, .peek_addr, .ready_r, .pc_r, .w_r,
        .page_high_latch_r, .status_r, .stack_top_r, .stack_ptr_r, .watchdog_restart_r, .skip_pending_r, .peek_data_r);
    always #2 mclk = ~mclk;
    task report_and_stop;
        $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task issue(input bcce_pkg::bcce_op_e op, input logic [6:0] f, input logic [2:0] b, input logic d,
               input logic [10:0] k);
        @(negedge mclk);
        instr <= {1'b1, op, f, b, d, k};
        @(negedge mclk);
        instr.valid <= 1'b0;
        epc = (op == bcce_pkg::BCCE_CALL) ? {ep[6:3], k} : (op == bcce_pkg::BCCE_INDIRECT_SUBROUTINE_CALL) ? {ep, ew} : epc + 15'h1;
        `CHK(pc_r, epc)
    endtask : issue
    task peek(input logic [6:0] f, input logic [7:0] e);
        @(negedge mclk);
        peek_addr = f;
        @(negedge mclk);
        `CHK(peek_data_r, e)
    endtask : peek
    task t_bits;
        issue(bcce_pkg::BCCE_CLR, 7'h05, 3'h0, 1'b0, 11'h000);
        `CHK(status_r.zero_flag, 1'b1)
        peek(7'h05, 8'h00);
        issue(bcce_pkg::BCCE_BSET, 7'h05, 3'h7, 1'b0, 11'h000);
        `CHK(status_r.zero_flag, 1'b1)
        peek(7'h05, 8'h80);
    endtask : t_bits
    task t_arith;
        issue(bcce_pkg::BCCE_COMP, 7'h05, 3'h0, 1'b0, 11'h000);
        `CHK({w_r, status_r.zero_flag}, 9'h0fe)
        issue(bcce_pkg::BCCE_COMP, 7'h05, 3'h0, 1'b1, 11'h000);
        peek(7'h05, 8'h7f);
        issue(bcce_pkg::BCCE_DEC, 7'h05, 3'h0, 1'b1, 11'h000);
        peek(7'h05, 8'h7e);
        issue(bcce_pkg::BCCE_DEC, 7'h05, 3'h0, 1'b0, 11'h000);
        `CHK(w_r, 8'h7d)
        issue(bcce_pkg::BCCE_CLR, 7'h06, 3'h0, 1'b0, 11'h000);
        issue(bcce_pkg::BCCE_BSET, 7'h06, 3'h0, 1'b0, 11'h000);
        issue(bcce_pkg::BCCE_COMP, 7'h06, 3'h0, 1'b0, 11'h000);
        `CHK({w_r, status_r.zero_flag}, 9'h1fc)
        issue(bcce_pkg::BCCE_DEC, 7'h06, 3'h0, 1'b1, 11'h000);
        `CHK(status_r, 3'h7)
    endtask : t_arith
    task t_skip;
        issue(bcce_pkg::BCCE_BSET, 7'h06, 3'h3, 1'b0, 11'h000);
        issue(bcce_pkg::BCCE_SKIP1, 7'h06, 3'h3, 1'b0, 11'h000);
        `CHK(skip_pending_r, 1'b1)
        issue(bcce_pkg::BCCE_COMP, 7'h06, 3'h0, 1'b0, 11'h000);
        `CHK({w_r, skip_pending_r}, 9'h1fc)
        issue(bcce_pkg::BCCE_SKIP1, 7'h06, 3'h0, 1'b0, 11'h000);
        issue(bcce_pkg::BCCE_COMP, 7'h06, 3'h0, 1'b0, 11'h000);
        `CHK(w_r, 8'hf7)
    endtask : t_skip
    task t_calls;
        @(negedge mclk);
        page_we = 1'b1;
        page_wdata = 7'h5a;
        @(negedge mclk);
        page_we = 1'b0;
        `CHK(page_high_latch_r, 7'h5a)
        ep = 7'h5a;
        old = epc;
        issue(bcce_pkg::BCCE_CALL, 7'h00, 3'h0, 1'b0, 11'h123);
        `CHK({stack_top_r, ready_r}, {old + 15'h1, 1'b0})
        `CHK(stack_ptr_r, 4'h1)
        ew = 8'hf7;
        old = epc;
        issue(bcce_pkg::BCCE_INDIRECT_SUBROUTINE_CALL, 7'h00, 3'h0, 1'b0, 11'h000);
        `CHK({stack_top_r, ready_r}, {old + 15'h1, 1'b0})
        `CHK(stack_ptr_r, 4'h2)
        @(negedge mclk);
        `CHK({ready_r, pc_r}, {1'b1, epc})
        issue(bcce_pkg::BCCE_WDTR, 7'h00, 3'h0, 1'b0, 11'h000);
        `CHK({watchdog_restart_r, status_r.time_out_flag, status_r.power_down_flag}, 3'h7)
        @(negedge mclk);
        `CHK(watchdog_restart_r, 1'b0)
    endtask : t_calls
    initial begin
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        t_bits();
        t_arith();
        t_skip();
        t_calls();
        report_and_stop();
    end
endmodule : bcce_exec_tb
bind bcce_exec bcce_chk bcce_chk_i (.mclk, .rst_n, .instr, .ready_r, .pc_r, .w_r, .page_high_latch_r, .status_r,
    .stack_top_r, .watchdog_restart_r, .skip_pending_r);
`default_nettype wire
